//--- rtl/ler_apb_if.sv
interface ler_apb_if;
    logic [11:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave(input addr, input wr, input rd, input wdata, output rdata);
    modport core(output addr, output wr, output rd, output wdata, input rdata);
endinterface

//--- rtl/ler_apb_regs.sv
`include "ler_regs.svh"
module ler_apb_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register access
    ler_apb_if.slave bus,
    // Core state in
    input wire logic [31:0] stat_word,
    input wire logic [31:0] vars_word,
    input wire logic [31:0] cnt_word,
    // Control out
    output logic [31:0] ctrl,
    output logic [31:0] parm
);
    // ****************************************
    // Register storage
    // ****************************************
    wire sel_ctrl = bus.addr == `LER_OFF_CTRL;
    wire sel_parm = bus.addr == `LER_OFF_PARM;
    // Writable registers; control self-clears its pulse bits
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= 32'h00000000;
            parm <= `LER_RST_PARM;
        end else begin
            ctrl <= (bus.wr && sel_ctrl) ? bus.wdata : 32'h00000000;
            if (bus.wr && sel_parm) begin
                parm <= {24'h000000, bus.wdata[7:0]};
            end
        end
    end
    // Read mux, unmapped reads as zero
    assign bus.rdata = (bus.addr == `LER_OFF_STAT) ? stat_word :
                       (bus.addr == `LER_OFF_VARS) ? vars_word :
                       (bus.addr == `LER_OFF_PARM) ? parm :
                       (bus.addr == `LER_OFF_CNT) ? cnt_word : 32'h00000000;
endmodule

//--- rtl/ler_core.sv
// The address map and the APB register port were decided locally.
`include "ler_regs.svh"
module ler_core #(
    parameter int ACK_TIMER_CYC = `LER_ACK_TIMER_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received frame, one-cycle strobe
    input wire logic rx_valid,
    input wire logic rx_ok,
    input wire ler_pkg::ler_frame_e rx_kind,
    input wire logic rx_cmd,
    input wire logic rx_pf,
    input wire ler_pkg::ler_seq_t rx_ns,
    input wire ler_pkg::ler_seq_t rx_nr,
    input wire logic rx_len_bad,
    input wire logic [15:0] rx_info_len,
    input wire logic rx_sabme,
    input wire logic rx_disc,
    // Receive octet stream for unbounded frame check
    input wire logic rx_octet,
    input wire logic rx_flag,
    // Layer 3 and transmit side events
    input wire logic link_up_request,
    input wire logic est_done,
    input wire logic tx_iframe,
    // Outputs
    output logic mgmt_error_ind,
    output logic link_up_ind,
    output logic link_up_confirm,
    output logic rx_payload_ind,
    output logic tx_sabme,
    output logic tx_rej,
    output logic tx_poll,
    output logic tx_final,
    output logic retx_start,
    output ler_pkg::ler_seq_t retx_from,
    output logic flush_queues,
    output logic rx_discard
);
    import ler_pkg::*;
    // ****************************************
    // Register file
    // ****************************************
    ler_apb_if rif();
    logic [31:0] ctrl;
    logic [31:0] parm;
    logic [31:0] stat_word;
    logic [31:0] vars_word;
    logic [31:0] cnt_word;
    logic [31:0] rd_q;
    ler_state_e state;
    ler_seq_t vs;
    ler_seq_t va;
    ler_seq_t vr;
    logic rej_exc;
    logic seq_err;
    logic l3_pending;
    logic [7:0] retx_cnt;
    logic [31:0] timer;
    logic timer_run;
    logic [15:0] octet_cnt;
    logic [15:0] err_cnt;
    // Bus decode: single access cycle per transfer
    assign rif.addr = paddr;
    assign rif.wr = psel && penable && pwrite;
    assign rif.rd = psel && !penable && !pwrite;
    assign rif.wdata = pwdata;
    ler_apb_regs u_regs (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(rif),
        .stat_word(stat_word),
        .vars_word(vars_word),
        .cnt_word(cnt_word),
        .ctrl(ctrl),
        .parm(parm)
    );
    assign stat_word = {24'h000000, l3_pending, seq_err, rej_exc, timer_run, 1'b0, state};
    assign vars_word = {9'h000, vr, 1'b0, va, 1'b0, vs};
    assign cnt_word = {8'h00, retx_cnt, err_cnt};
    // Read data captured in setup, ready in access phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_q <= 32'h00000000;
            pready <= 1'b0;
        end else begin
            if (rif.rd) begin
                rd_q <= rif.rdata;
            end
            pready <= psel && !penable;
        end
    end
    assign prdata = rd_q;
    assign pslverr = 1'b0;
    // ****************************************
    // Frame decode
    // ****************************************
    wire ctl_est = ctrl[0];
    wire ctl_rel = ctrl[1];
    wire ctl_set_long = ctrl[2];
    wire [7:0] max_retx = parm[7:0];
    wire mf_mode = (state == LER_ESTAB) || (state == LER_TIMER_REC);
    wire v = rx_valid && rx_ok;
    wire [6:0] nr_off = 7'(rx_nr - va);
    wire [6:0] vs_off = 7'(vs - va);
    wire nr_bad = nr_off > vs_off;
    wire is_i = rx_kind == LER_FR_I;
    wire is_sup = (rx_kind == LER_FR_RR) || (rx_kind == LER_FR_RNR) || (rx_kind == LER_FR_REJ);
    wire has_nr = is_i || is_sup;
    wire frej = v && ((rx_kind == LER_FR_OTHER && !rx_sabme && !rx_disc) || rx_len_bad ||
                (has_nr && mf_mode && nr_bad) || (rx_info_len > `LER_MAX_INFO));
    wire good = v && !frej;
    wire i_in_seq = good && is_i && mf_mode && (rx_ns == vr);
    wire i_out_seq = good && is_i && mf_mode && (rx_ns != vr);
    wire sup_resp = good && is_sup && !rx_cmd;
    wire ua_in = good && rx_kind == LER_FR_UA;
    wire dm_in = good && rx_kind == LER_FR_DM && !rx_cmd;
    wire awaiting = (state == LER_AWAIT_EST) || (state == LER_AWAIT_REL);
    wire ua_err = ua_in && (!rx_pf || !awaiting);
    wire dm_err = dm_in && ((rx_pf && mf_mode) || (!rx_pf && mf_mode));
    wire dm_reest = dm_in && mf_mode && (!rx_pf || state == LER_TIMER_REC);
    wire dm_est = dm_in && !rx_pf && state == LER_ASSIGNED;
    wire sup_err = sup_resp && rx_pf && state == LER_ESTAB;
    wire frmr_in = good && rx_kind == LER_FR_FRMR && mf_mode;
    wire sabme_in = good && rx_sabme;
    wire peer_reest = sabme_in && mf_mode;
    wire t_exp = timer_run && (timer == 32'h00000001);
    wire rec_exp = t_exp && (state == LER_TIMER_REC);
    wire retry_lim = rec_exp && ((retx_cnt + 8'h01) >= max_retx);
    wire ovr_long = rx_octet && !rx_flag &&
                    (octet_cnt >= 16'((`LER_MAX_INFO + 16'h0004) * 2 + 16'h0002));
    wire local_reest = (frej && mf_mode) || frmr_in || dm_reest || retry_lim;
    wire l3_reest = link_up_request && mf_mode;
    wire any_reest = local_reest || peer_reest || l3_reest;
    wire mgmt_evt = local_reest || peer_reest || frej || ua_err || dm_err || sup_err;
    // ****************************************
    // Link state machine
    // ****************************************
    ler_state_e next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            LER_ASSIGNED: begin
                if (dm_est || ctl_est || link_up_request) begin
                    next_state = LER_AWAIT_EST;
                end
            end
            LER_AWAIT_EST: begin
                if (est_done) begin
                    next_state = LER_ESTAB;
                end
            end
            LER_AWAIT_REL: begin
                if (est_done) begin
                    next_state = LER_ASSIGNED;
                end
            end
            LER_ESTAB: begin
                if (any_reest) begin
                    next_state = LER_AWAIT_EST;
                end else if (ctl_rel) begin
                    next_state = LER_AWAIT_REL;
                end else if (t_exp) begin
                    next_state = LER_TIMER_REC;
                end
            end
            LER_TIMER_REC: begin
                if (any_reest) begin
                    next_state = LER_AWAIT_EST;
                end else if (sup_resp && rx_pf) begin
                    next_state = LER_ESTAB;
                end
            end
        endcase
    end
    // State, sequence variables and exception flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= LER_ASSIGNED;
            vs <= 7'h00;
            va <= 7'h00;
            vr <= 7'h00;
            rej_exc <= 1'b0;
            seq_err <= 1'b0;
            l3_pending <= 1'b0;
        end else begin
            state <= next_state;
            if (any_reest || sabme_in) begin
                vs <= 7'h00;
                va <= 7'h00;
                vr <= 7'h00;
            end else begin
                if (tx_iframe) begin
                    vs <= 7'(vs + 7'h01);
                end
                if (good && has_nr && mf_mode) begin
                    va <= rx_nr;
                end
                if (i_in_seq) begin
                    vr <= 7'(vr + 7'h01);
                end
            end
            // Reject exception, only one at a time
            if (sabme_in || (good && rx_disc) || i_in_seq) begin
                rej_exc <= 1'b0;
                seq_err <= 1'b0;
            end else if (i_out_seq) begin
                seq_err <= 1'b1;
                rej_exc <= 1'b1;
            end
            if (l3_reest || (link_up_request && state == LER_AWAIT_EST)) begin
                l3_pending <= 1'b1;
            end else if (est_done) begin
                l3_pending <= 1'b0;
            end
        end
    end
    // ****************************************
    // Acknowledgement timer and retries
    // ****************************************
    wire [31:0] t_load = ctl_set_long ? 32'((ACK_TIMER_CYC * 5) / 2) : 32'(ACK_TIMER_CYC);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer <= 32'h00000000;
            timer_run <= 1'b0;
            retx_cnt <= 8'h00;
        end else begin
            if (t_exp && state == LER_ESTAB) begin
                retx_cnt <= 8'h00;
            end else if (rec_exp) begin
                retx_cnt <= 8'(retx_cnt + 8'h01);
            end
            if (any_reest || (t_exp && !retry_lim) || tx_iframe) begin
                timer <= t_load;
                timer_run <= 1'b1;
            end else if (sup_resp && rx_pf && state == LER_TIMER_REC) begin
                timer_run <= 1'b0;
            end else if (timer_run) begin
                timer <= 32'(timer - 32'h00000001);
            end
        end
    end
    // Unbounded frame octet counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            octet_cnt <= 16'h0000;
        end else if (rx_flag) begin
            octet_cnt <= 16'h0000;
        end else if (rx_octet && !ovr_long) begin
            octet_cnt <= 16'(octet_cnt + 16'h0001);
        end
    end
    // ****************************************
    // Output events
    // ****************************************
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mgmt_error_ind <= 1'b0;
            link_up_ind <= 1'b0;
            link_up_confirm <= 1'b0;
            rx_payload_ind <= 1'b0;
            tx_sabme <= 1'b0;
            tx_rej <= 1'b0;
            tx_poll <= 1'b0;
            tx_final <= 1'b0;
            retx_start <= 1'b0;
            retx_from <= 7'h00;
            flush_queues <= 1'b0;
            rx_discard <= 1'b0;
            err_cnt <= 16'h0000;
        end else begin
            mgmt_error_ind <= mgmt_evt;
            link_up_ind <= (local_reest || peer_reest) && !l3_reest && (vs != va);
            link_up_confirm <= est_done && state == LER_AWAIT_EST && l3_pending;
            rx_payload_ind <= i_in_seq;
            tx_sabme <= local_reest || l3_reest || dm_est;
            tx_rej <= i_out_seq && !rej_exc;
            tx_poll <= t_exp && mf_mode && !retry_lim;
            tx_final <= good && has_nr && rx_cmd && rx_pf && mf_mode;
            retx_start <= good && rx_kind == LER_FR_REJ && mf_mode;
            if (good && rx_kind == LER_FR_REJ) begin
                retx_from <= rx_nr;
            end
            flush_queues <= (local_reest || peer_reest) && (vs != va);
            rx_discard <= (rx_valid && !rx_ok) || i_out_seq || frej || ovr_long;
            if (mgmt_evt) begin
                err_cnt <= 16'(err_cnt + 16'h0001);
            end
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    bad_nr_err_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (v && has_nr && mf_mode && nr_bad) |=> mgmt_error_ind)
        else $error("bad receive number gave no error");
    reest_sabme_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (frej && mf_mode) |=> tx_sabme)
        else $error("rejection in multiple-frame mode did not re-establish");
    norej_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (frej && !mf_mode && !link_up_request) |=> !tx_sabme && mgmt_error_ind)
        else $error("rejection outside mode mishandled");
    invalid_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (rx_valid && !rx_ok && !any_reest && !tx_iframe) |=> $stable(vr) && !mgmt_error_ind)
        else $error("invalid frame caused action");
    seq_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        i_out_seq |=> $stable(vr) && !rx_payload_ind && rx_discard)
        else $error("out of sequence frame advanced receive count");
    one_rej_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (i_out_seq && rej_exc) |=> !tx_rej)
        else $error("second reject sent");
    rej_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sabme_in |=> !rej_exc)
        else $error("reject exception not cleared");
    ua_dup_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ua_in && (state == LER_ESTAB || state == LER_ASSIGNED)) |=> mgmt_error_ind)
        else $error("duplicate identifier not reported");
    retry_limit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        retry_lim |=> tx_sabme && mgmt_error_ind && !tx_poll)
        else $error("retry limit not handled");
endmodule

//--- rtl/ler_pkg.sv
package ler_pkg;
    // Link states
    typedef enum logic [2:0] {
        LER_ASSIGNED = 3'b000,
        LER_AWAIT_EST = 3'b001,
        LER_AWAIT_REL = 3'b010,
        LER_ESTAB = 3'b011,
        LER_TIMER_REC = 3'b100
    } ler_state_e;
    // Received frame kinds
    typedef enum logic [2:0] {
        LER_FR_I = 3'b000,
        LER_FR_RR = 3'b001,
        LER_FR_RNR = 3'b010,
        LER_FR_REJ = 3'b011,
        LER_FR_UA = 3'b100,
        LER_FR_DM = 3'b101,
        LER_FR_FRMR = 3'b110,
        LER_FR_OTHER = 3'b111
    } ler_frame_e;
    typedef logic [6:0] ler_seq_t;
endpackage

//--- rtl/ler_regs.svh
`ifndef LER_REGS_SVH
`define LER_REGS_SVH
// Summary of operation
// - Self-detected re-establishment condition sends the establishment command.
// - Self-detected or peer re-establishment raises a management error; pending sends also flush, and indicate up unless layer 3 requests in the same cycle.
// - Layer 3 requested re-establishment completes with a link-up confirm.
// - A valid I frame with unexpected send number flags a sequence error, payload dropped.
// - No acknowledge or receive-count advance until the expected I frame arrives.
// - Out-of-sequence I and supervisory frames still get N(R) and poll/final processed.
// - Reject starts recovery; at most one reject exception active at a time.
// - A received reject restarts transmission from the number it carries.
// - Reject exception clears on expected I frame, establishment or disconnect command.
// - Receive number outside acknowledge..send range raises error and re-establishes.
// - Frames failing validity checks are dropped with no effect.
// - Undefined, wrong-length, bad N(R) or oversize frames make a rejection condition.
// - Rejection condition in multiple-frame operation raises error then re-establishes.
// - Rejection condition elsewhere raises error and drops the frame only.
// - Frames longer than twice (maximum information field plus four) plus two octets without flag are dropped.
// - Received frame reject response in multiple-frame operation: error and re-establish.
// - Unsolicited UA raises error; UA final 1 solicited only while awaiting.
// - Unsolicited DM handled per state: ignore, error, establish or re-establish.
// - Unsolicited supervisory responses ignored outside multiple-frame; final 1 errors in established state.
// - UA in established, timer recovery or assigned state reports duplicate identifier.
// - Maximum retransmission count defaults to 3.
// - Timer expiry in recovery polls below the limit, re-establishes at the limit.
// - Sequence numbers count modulo 128, at most 127 outstanding.

// ****************************************
// Timing and parameter defaults
// ****************************************
`define LER_CLK_HZ 20000000
`define LER_ACK_TIMER_MS 1000
`define LER_ACK_TIMER_CYC (`LER_ACK_TIMER_MS * (`LER_CLK_HZ / 1000))
`define LER_MAX_RETX 8'h03
`define LER_MAX_INFO 16'h0104
`define LER_SEQ_MASK 7'h7F
// ****************************************
// Register offsets
// ****************************************
`define LER_OFF_CTRL 12'h000
`define LER_OFF_STAT 12'h004
`define LER_OFF_VARS 12'h008
`define LER_OFF_PARM 12'h00C
`define LER_OFF_CNT 12'h010
// ****************************************
// Reset values
// ****************************************
`define LER_RST_PARM 32'h00000003
`endif

//--- test/ler_peer_model.sv
module ler_peer_model (
    // Clock
    input wire logic ref_clk,
    // Device events seen by the peer
    input wire logic tx_rej,
    input wire logic rx_payload_ind,
    // Frame descriptor towards the device
    output logic rx_valid,
    output logic rx_ok,
    output ler_pkg::ler_frame_e rx_kind,
    output logic rx_cmd,
    output logic rx_pf,
    output ler_pkg::ler_seq_t rx_ns,
    output ler_pkg::ler_seq_t rx_nr,
    output logic rx_len_bad,
    output logic [15:0] rx_info_len
);
    timeunit 1ns;
    timeprecision 1ns;
    import ler_pkg::*;
    ler_seq_t next_ns = 7'h00;
    ler_seq_t acked = 7'h00;
    logic rej_seen = 1'b0;
    // Quiet descriptor at time zero
    initial begin
        {rx_valid, rx_ok, rx_cmd, rx_pf, rx_len_bad} = 5'h00;
        {rx_ns, rx_nr, rx_info_len} = 30'h0;
        rx_kind = LER_FR_OTHER;
    end
    // Count accepted frames, note reject requests
    always @(posedge ref_clk) begin
        if (rx_payload_ind === 1'b1)
            acked <= acked + 7'h01;
        if (tx_rej === 1'b1)
            rej_seen <= 1'b1;
    end
    // One frame, then inverted leftovers so stale fields never look valid
    task automatic send(input ler_frame_e k, input logic c, p, input ler_seq_t s, r,
        input logic ok, bad);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        {rx_ok, rx_cmd, rx_pf, rx_len_bad} <= {ok, c, p, bad};
        {rx_kind, rx_ns, rx_nr, rx_info_len} <= {k, s, r, 16'h0020};
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        {rx_ok, rx_cmd, rx_pf, rx_len_bad} <= ~{ok, c, p, bad};
        {rx_ns, rx_nr, rx_info_len} <= ~{s, r, 16'h0020};
        rx_kind <= ler_frame_e'(~k);
    endtask
    // Next I frame in order; after a reject restart from the first unaccepted one
    task automatic send_seq(input logic p);
        if (rej_seen) begin
            next_ns = acked;
            rej_seen = 1'b0;
        end
        send(LER_FR_I, 1'b1, p, next_ns, 7'h00, 1'b1, 1'b0);
        next_ns = next_ns + 7'h01;
    endtask
endmodule

//--- test/link_exception_recovery_tb_top.sv
`include "ler_regs.svh"
module link_exception_recovery_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ler_pkg::*;
    localparam int K_ERR = 0, K_IND = 1, K_CONF = 2, K_PAY = 3, K_SAB = 4, K_REJ = 5;
    localparam int K_POLL = 6, K_FIN = 7, K_RETX = 8, K_FLUSH = 9, K_DISC = 10;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [4:0] ev = 5'h0;
    logic rx_valid, rx_ok, rx_cmd, rx_pf, rx_len_bad;
    ler_frame_e rx_kind;
    ler_seq_t rx_ns, rx_nr, retx_from;
    logic [15:0] rx_info_len;
    logic [10:0] outs;
    logic [7:0] cnt [11];
    logic clr = 1'b0;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    // Design under test with a short acknowledgement timer
    ler_core #(.ACK_TIMER_CYC(100)) u_ler_core (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_ok(rx_ok),
        .rx_kind(rx_kind), .rx_cmd(rx_cmd), .rx_pf(rx_pf), .rx_ns(rx_ns), .rx_nr(rx_nr),
        .rx_len_bad(rx_len_bad), .rx_info_len(rx_info_len), .rx_sabme(ev[3]),
        .rx_disc(ev[4]), .rx_octet(1'b0), .rx_flag(1'b0), .link_up_request(ev[0]),
        .est_done(ev[1]), .tx_iframe(ev[2]), .mgmt_error_ind(outs[K_ERR]),
        .link_up_ind(outs[K_IND]), .link_up_confirm(outs[K_CONF]),
        .rx_payload_ind(outs[K_PAY]), .tx_sabme(outs[K_SAB]), .tx_rej(outs[K_REJ]),
        .tx_poll(outs[K_POLL]), .tx_final(outs[K_FIN]), .retx_start(outs[K_RETX]),
        .retx_from(retx_from), .flush_queues(outs[K_FLUSH]), .rx_discard(outs[K_DISC]));
    // Far-side link entity
    ler_peer_model u_ler_peer_model (
        .ref_clk(ref_clk), .tx_rej(outs[K_REJ]), .rx_payload_ind(outs[K_PAY]),
        .rx_valid(rx_valid), .rx_ok(rx_ok), .rx_kind(rx_kind), .rx_cmd(rx_cmd),
        .rx_pf(rx_pf), .rx_ns(rx_ns), .rx_nr(rx_nr), .rx_len_bad(rx_len_bad),
        .rx_info_len(rx_info_len));
    // Clock
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // Pulse counters per output, plus hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < 11; i++) begin
            if (clr)
                cnt[i] <= 8'h00;
            else if (outs[i] === 1'b1)
                cnt[i] <= cnt[i] + 8'h01;
        end
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_cnt(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected pulse count at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] mask, exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check_reg(q & mask, exp);
    endtask
    task automatic pulse(input int b);
        @(posedge ref_clk);
        ev[b] <= 1'b1;
        @(posedge ref_clk);
        ev[b] <= 1'b0;
    endtask
    task automatic clear_cnt();
        @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
    endtask
    function automatic ler_frame_e ukind(input int i);
        return i < 2 ? LER_FR_UA : i < 4 ? LER_FR_DM : i < 6 ? LER_FR_RR : LER_FR_FRMR;
    endfunction
    // Unsolicited response in established state: {re-establish, error}
    function automatic logic [1:0] exp_unsol(input ler_frame_e k, input logic f);
        case (k)
            LER_FR_UA: return 2'b01;
            LER_FR_DM: return f ? 2'b01 : 2'b11;
            LER_FR_FRMR: return 2'b11;
            default: return f ? 2'b01 : 2'b00;
        endcase
    endfunction
    // Main sequence
    initial begin
        logic [31:0] q;
        logic [1:0] e;
        ler_seq_t k;
        int n;
        void'($urandom(91928));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk(`LER_OFF_PARM, 32'hFF, 32'h3);
        rd_chk(`LER_OFF_VARS, 32'hFFFFFFFF, 32'h0);
        rd_chk(12'h014, 32'hFFFFFFFF, 32'h0);
        clear_cnt();
        u_ler_peer_model.send(LER_FR_UA, 1'b0, 1'b1, 7'h00, 7'h00, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_ERR], 8'h01);
        apb(1'b1, `LER_OFF_CTRL, 32'h1, q);
        pulse(1);
        rd_chk(`LER_OFF_STAT, 32'h7, 32'h3);
        clear_cnt();
        u_ler_peer_model.send_seq(1'b0);
        u_ler_peer_model.send(LER_FR_I, 1'b1, 1'b0, 7'($urandom_range(2, 127)), 7'h00, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_PAY], 8'h01);
        check_cnt(cnt[K_REJ], 8'h01);
        check_cnt(cnt[K_DISC], 8'h01);
        clear_cnt();
        u_ler_peer_model.send(LER_FR_I, 1'b1, 1'b1, 7'($urandom_range(2, 127)), 7'h00, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_REJ], 8'h00);
        check_cnt(cnt[K_FIN], 8'h01);
        check_cnt(cnt[K_PAY], 8'h00);
        rd_chk(`LER_OFF_STAT, 32'h20, 32'h20);
        ev[4] <= 1'b1;
        u_ler_peer_model.send(LER_FR_OTHER, 1'b1, 1'b0, 7'h00, 7'h00, 1'b1, 1'b0);
        ev[4] <= 1'b0;
        rd_chk(`LER_OFF_STAT, 32'h20, 32'h0);
        clear_cnt();
        u_ler_peer_model.send_seq(1'b0);
        u_ler_peer_model.send(LER_FR_I, 1'b1, 1'b0, 7'h02, 7'h00, 1'b0, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_PAY], 8'h01);
        check_cnt(cnt[K_ERR], 8'h00);
        rd_chk(`LER_OFF_STAT, 32'h20, 32'h0);
        rd_chk(`LER_OFF_VARS, 32'h7F0000, 32'h20000);
        clear_cnt();
        ev[3] <= 1'b1;
        u_ler_peer_model.send(LER_FR_OTHER, 1'b1, 1'b0, 7'h00, 7'h00, 1'b1, 1'b0);
        ev[3] <= 1'b0;
        pulse(1);
        u_ler_peer_model.send(LER_FR_RR, 1'b1, 1'b0, 7'h00, 7'h09, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_ERR], 8'h02);
        check_cnt(cnt[K_SAB], 8'h01);
        clear_cnt();
        u_ler_peer_model.send(LER_FR_RR, 1'b0, 1'b0, 7'h00, 7'h00, 1'b1, 1'b1);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_ERR], 8'h01);
        check_cnt(cnt[K_SAB], 8'h00);
        clear_cnt();
        pulse(0);
        pulse(1);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_CONF], 8'h01);
        check_cnt(cnt[K_IND], 8'h00);
        for (int i = 0; i < 7; i++) begin
            clear_cnt();
            u_ler_peer_model.send(ukind(i), 1'b0, i[0], 7'h00, 7'h00, 1'b1, 1'b0);
            repeat (3) @(posedge ref_clk);
            e = exp_unsol(ukind(i), i[0]);
            check_cnt(cnt[K_ERR], {7'h00, e[0]});
            check_cnt(cnt[K_SAB], {7'h00, e[1]});
            if (e[1])
                pulse(1);
        end
        repeat (3) pulse(2);
        k = 7'($urandom_range(0, 2));
        clear_cnt();
        u_ler_peer_model.send(LER_FR_REJ, 1'b0, 1'b0, 7'h00, k, 1'b1, 1'b0);
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_RETX], 8'h01);
        check_reg({25'h0, retx_from}, {25'h0, k});
        rd_chk(`LER_OFF_VARS, 32'h7F7F, {17'h0, k, 8'h03});
        clear_cnt();
        n = 0;
        while (cnt[K_SAB] === 8'h00 && n < 800) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (3) @(posedge ref_clk);
        check_cnt(cnt[K_POLL], 8'h03);
        check_cnt(cnt[K_ERR], 8'h01);
        check_cnt(cnt[K_FLUSH], 8'h01);
        check_cnt(cnt[K_IND], 8'h01);
        finish_test();
    end
endmodule
